// [core/umtc_consts.vh]
// Purpose: shared offsets, field positions and reset values of the serial control block
// Assumes: 8-bit register port, byte offsets on word boundaries
// Notes:   included by every design file of the block
`ifndef UMTC_CONSTS_VH
`define UMTC_CONSTS_VH

// register offsets on the plain register port
`define UMTC_ADDR_MODE      8'h00
`define UMTC_ADDR_CTRL      8'h04
`define UMTC_ADDR_STATUS    8'h08
`define UMTC_ADDR_RXDATA    8'h0C
`define UMTC_ADDR_TXDATA    8'h10
`define UMTC_ADDR_IRQ_STAT  8'h14
`define UMTC_ADDR_IRQ_MASK  8'h18

// serial_mode_reg fields
`define UMTC_MODE_SYNC      7
`define UMTC_MODE_MP        2

// serial_control_reg fields
`define UMTC_CTRL_TIE       7
`define UMTC_CTRL_RIE       6
`define UMTC_CTRL_TE        5
`define UMTC_CTRL_RE        4
`define UMTC_CTRL_MULTIPROC_IRQ_ENABLE      3
`define UMTC_CTRL_TX_END_IRQ_ENABLE      2

// serial_status_reg fields
`define UMTC_STAT_TX_EMPTY_FLAG      7
`define UMTC_STAT_RX_FULL_FLAG      6
`define UMTC_STAT_OVERRUN_FLAG      5
`define UMTC_STAT_FER       4
`define UMTC_STAT_TX_END_FLAG      2
`define UMTC_STAT_MPB       1

// interrupt status and mask fields
`define UMTC_IRQ_RXF        0
`define UMTC_IRQ_RXE        1
`define UMTC_IRQ_TX_END_FLAG       2
`define UMTC_IRQ_TXE        3

// reset values
`define UMTC_RST_MODE       8'h00
`define UMTC_RST_CTRL       8'h00
`define UMTC_RST_STATUS     8'h84
`define UMTC_RST_DATA       8'h00
`define UMTC_RST_IRQ        4'h0

`endif

// [core/umtc_rx_gate.v]
// Purpose: decides what a finished receive frame may do to the receive flags
// Assumes: frame done is a one-cycle pulse with data, multiproc bit and framing error valid beside it
// Notes:   purely combinational, the top module owns all state
`timescale 1ns/1ps
`include "umtc_consts.vh"

module umtc_rx_gate (
	input  wire       i_frame_done,   // receiver finished a frame
	input  wire       i_frame_mpb,    // multiproc bit of that frame
	input  wire       i_frame_ferr,   // stop bit was bad
	input  wire       i_multiproc_irq_enable,         // multiproc irq enable as stored
	input  wire       i_sync_mode,    // clock synchronous mode selected
	input  wire       i_mp_mode,      // multiproc mode selected
	input  wire       i_rx_full,      // receive data register still unread
	output reg        o_accept,       // move frame into receive data register
	output reg        o_set_fer,      // raise framing error flag
	output reg        o_set_overrun_flag,     // raise overrun flag
	output reg        o_id_seen,      // frame ended a filtering period
	output reg        o_mpb_upd       // update multiproc bit flag
);

	reg filtering;                    // filter actually in force

	// one decision per frame
	always @* begin
		// enable only counts in async multiproc mode
		filtering  = i_multiproc_irq_enable & ~i_sync_mode & i_mp_mode;
		o_accept   = 1'b0;
		o_set_fer  = 1'b0;
		o_set_overrun_flag = 1'b0;
		o_id_seen  = 1'b0;
		o_mpb_upd  = 1'b0;
		if (i_frame_done) begin
			if (!filtering) begin
				// normal receive, no filtering on the multiproc bit
				o_mpb_upd  = i_mp_mode & ~i_sync_mode;
				o_set_overrun_flag = i_rx_full;
				o_accept   = ~i_rx_full;
				o_set_fer  = i_frame_ferr & ~i_rx_full;
			end else if (i_frame_mpb) begin
				// id frame ends filtering, flags may be set again
				o_id_seen  = 1'b1;
				o_mpb_upd  = 1'b1;
				o_set_overrun_flag = i_rx_full;
				o_accept   = ~i_rx_full;
				o_set_fer  = i_frame_ferr & ~i_rx_full;
			end else begin
				// data frame for another station: no transfer, no error
				o_accept   = 1'b0;
			end
		end
	end

endmodule

// [core/umtc_ctrl.v]
// Purpose: serial control and status registers with multiproc filtering and transmit-end request
// Assumes: receiver and transmitter shift logic sit outside and talk through pulses
// Notes:   all outputs registered, so requests trail their flags by one clock
//
// Functional notes
// - multiproc enable counts only in async multiproc mode
// - enable clear means normal reception, no filtering
// - enable set suppresses receive requests and flags
// - while filtering, no transfer and no error detection
// - enable cleared by software zero or id frame
// - id frame sets multiproc bit flag
// - id frame clears enable, error flags allowed again
// - id frame raises receive requests if enabled
// - transmit end when msb sent, no data waiting
// - transmit end enable gates transmit end request
// - request dropped by clearing enable or both flags
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`include "umtc_consts.vh"

module umtc_ctrl (
	input  wire       I_SYS_CLK,        // peripheral clock, 20 MHz
	input  wire       I_RST,            // asynchronous reset, active high
	input  wire       I_CE,             // clock enable, freezes all state while low
	input  wire [7:0] I_ADDR,           // register byte address
	input  wire [7:0] I_WDATA,          // register write data
	input  wire       I_WR,             // write strobe
	input  wire       I_RD,             // read strobe
	input  wire       I_RX_FRAME_DONE,  // receiver finished a frame, one cycle
	input  wire [7:0] I_RX_DATA,        // received data byte
	input  wire       I_RX_MPB,         // received multiproc bit
	input  wire       I_RX_FERR,        // received stop bit was bad
	input  wire       I_TX_TAKE,        // transmitter loaded the transmit data, one cycle
	input  wire       I_TX_MSB,         // transmitter shifting the msb of a frame, one cycle
	output reg  [7:0] O_RDATA,          // read data, valid the cycle after a read
	output reg  [7:0] O_TX_DATA,        // byte offered to the transmitter
	output reg        O_TX_VALID,       // transmit data waiting for the transmitter
	output reg        O_RX_ENABLE,      // receiver enabled
	output reg        O_TX_ENABLE,      // transmitter enabled
	output reg        O_RX_FULL_REQ,    // receive-data-full request
	output reg        O_RX_ERROR_REQ,   // receive-error request
	output reg        O_TX_EMPTY_REQ,   // transmit-empty request
	output reg        O_TX_END_REQ,     // transmit-end request
	output reg        O_IRQ             // combined interrupt, level
);

	// flag update where a hardware set always beats a clear
	function flag_upd;
		input cur;
		input set;
		input clr;
		begin
			flag_upd = set | (cur & ~clr);
		end
	endfunction

	// reset image of the status flags, bit-selected so no reset value is truncated
	localparam [7:0] rst_status = `UMTC_RST_STATUS;

	// register image
	reg  [7:0] mode_r;                  // serial mode register
	reg  [7:0] ctrl_r;                  // serial control register
	reg  [7:0] rx_data_r;               // receive data register
	reg  [7:0] tx_data_r;               // transmit data register
	reg        tx_empty_flag_r;                  // transmit empty flag
	reg        rx_full_flag_r;                  // receive full flag
	reg        overrun_flag_r;                  // overrun flag
	reg        fer_r;                   // framing error flag
	reg        tx_end_flag_r;                  // transmit end flag
	reg        mpb_r;                   // multiproc bit flag
	reg  [7:0] arm_r;                   // status bits read as one, ready for a zero write
	reg  [3:0] irq_stat_r;              // sticky interrupt status
	reg  [3:0] irq_mask_r;              // interrupt mask
	reg  [3:0] req_prev_r;              // requests one clock ago, for edge capture

	// next values
	reg  [7:0] ctrl_nxt;
	reg        tx_empty_flag_nxt;
	reg        rx_full_flag_nxt;
	reg        overrun_flag_nxt;
	reg        fer_nxt;
	reg        tx_end_flag_nxt;
	reg        mpb_nxt;
	reg  [3:0] req_nxt;

	// decoded strobes
	wire       wr_mode   = I_WR & (I_ADDR == `UMTC_ADDR_MODE);
	wire       wr_ctrl   = I_WR & (I_ADDR == `UMTC_ADDR_CTRL);
	wire       wr_stat   = I_WR & (I_ADDR == `UMTC_ADDR_STATUS);
	wire       wr_tx     = I_WR & (I_ADDR == `UMTC_ADDR_TXDATA);
	wire       wr_istat  = I_WR & (I_ADDR == `UMTC_ADDR_IRQ_STAT);
	wire       wr_imask  = I_WR & (I_ADDR == `UMTC_ADDR_IRQ_MASK);
	wire       rd_stat   = I_RD & (I_ADDR == `UMTC_ADDR_STATUS);

	// zero write to an armed status bit clears it
	wire [7:0] stat_clr  = {8{wr_stat}} & ~I_WDATA & arm_r;

	// frame decisions from the gate
	wire       g_accept;
	wire       g_set_fer;
	wire       g_set_overrun_flag;
	wire       g_id_seen;
	wire       g_mpb_upd;

	// receiver disabled: finished frames are dropped
	wire       frame_ok  = I_RX_FRAME_DONE & ctrl_r[`UMTC_CTRL_RE];

	umtc_rx_gate u_gate (
		.i_frame_done (frame_ok),
		.i_frame_mpb  (I_RX_MPB),
		.i_frame_ferr (I_RX_FERR),
		.i_multiproc_irq_enable       (ctrl_r[`UMTC_CTRL_MULTIPROC_IRQ_ENABLE]),
		.i_sync_mode  (mode_r[`UMTC_MODE_SYNC]),
		.i_mp_mode    (mode_r[`UMTC_MODE_MP]),
		.i_rx_full    (rx_full_flag_r),
		.o_accept     (g_accept),
		.o_set_fer    (g_set_fer),
		.o_set_overrun_flag   (g_set_overrun_flag),
		.o_id_seen    (g_id_seen),
		.o_mpb_upd    (g_mpb_upd)
	);

	// status view as software reads it
	wire [7:0] stat_view = {tx_empty_flag_r, rx_full_flag_r, overrun_flag_r, fer_r, 1'b0, tx_end_flag_r, mpb_r, 1'b0};

	// control register next value
	always @* begin
		ctrl_nxt = ctrl_r;
		if (wr_ctrl) begin
			// software write, a zero clears the multiproc enable
			ctrl_nxt = I_WDATA;
		end
		if (g_id_seen) begin
			// id frame clears the enable, wins over a same-cycle write
			ctrl_nxt[`UMTC_CTRL_MULTIPROC_IRQ_ENABLE] = 1'b0;
		end
	end

	// status flag next values
	always @* begin
		// only accepted frames set full and framing error, overrun only on a frame refused while full; none during filtering
		rx_full_flag_nxt = flag_upd(rx_full_flag_r, g_accept, stat_clr[`UMTC_STAT_RX_FULL_FLAG]);
		fer_nxt  = flag_upd(fer_r, g_set_fer, stat_clr[`UMTC_STAT_FER]);
		overrun_flag_nxt = flag_upd(overrun_flag_r, g_set_overrun_flag, stat_clr[`UMTC_STAT_OVERRUN_FLAG]);
		// id frame sets the multiproc bit flag
		mpb_nxt  = g_mpb_upd ? I_RX_MPB : mpb_r;
		// transmitter took the byte: register empty again
		tx_empty_flag_nxt = flag_upd(tx_empty_flag_r, I_TX_TAKE, stat_clr[`UMTC_STAT_TX_EMPTY_FLAG]);
		// msb going out with nothing new waiting ends transmission
		tx_end_flag_nxt = flag_upd(tx_end_flag_r, I_TX_MSB & tx_empty_flag_r, stat_clr[`UMTC_STAT_TX_END_FLAG]);
		// new data written and released clears the end flag as well
		if (stat_clr[`UMTC_STAT_TX_EMPTY_FLAG] && !I_TX_MSB) begin
			tx_end_flag_nxt = 1'b0;
		end
		if (!ctrl_r[`UMTC_CTRL_TE]) begin
			// transmitter off: empty flag held at one
			tx_empty_flag_nxt = 1'b1;
		end
	end

	// request next values from the flags as they now stand
	always @* begin
		req_nxt                = 4'h0;
		// receive requests only once the flags may be set, and only with enable
		req_nxt[`UMTC_IRQ_RXF] = rx_full_flag_r & ctrl_r[`UMTC_CTRL_RIE];
		req_nxt[`UMTC_IRQ_RXE] = (fer_r | overrun_flag_r) & ctrl_r[`UMTC_CTRL_RIE];
		// end flag and enable, withdrawn when either drops
		req_nxt[`UMTC_IRQ_TX_END_FLAG] = tx_end_flag_r & ctrl_r[`UMTC_CTRL_TX_END_IRQ_ENABLE];
		req_nxt[`UMTC_IRQ_TXE]  = tx_empty_flag_r & ctrl_r[`UMTC_CTRL_TIE] & ctrl_r[`UMTC_CTRL_TE];
	end

	// register file, flags and data
	always @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			mode_r     <= `UMTC_RST_MODE;
			ctrl_r     <= `UMTC_RST_CTRL;
			rx_data_r  <= `UMTC_RST_DATA;
			tx_data_r  <= `UMTC_RST_DATA;
			tx_empty_flag_r     <= rst_status[`UMTC_STAT_TX_EMPTY_FLAG];
			rx_full_flag_r     <= 1'b0;
			overrun_flag_r     <= 1'b0;
			fer_r      <= 1'b0;
			tx_end_flag_r     <= rst_status[`UMTC_STAT_TX_END_FLAG];
			mpb_r      <= 1'b0;
			arm_r      <= 8'h00;
		end else if (I_CE) begin
			// mode writes; changing mode mid-frame is the user's hazard
			if (wr_mode) begin
				mode_r <= I_WDATA;
			end
			ctrl_r <= ctrl_nxt;
			if (wr_tx) begin
				tx_data_r <= I_WDATA;
			end
			// shift register to data register only when accepted
			if (g_accept) begin
				rx_data_r <= I_RX_DATA;
			end
			tx_empty_flag_r <= tx_empty_flag_nxt;
			rx_full_flag_r <= rx_full_flag_nxt;
			overrun_flag_r <= overrun_flag_nxt;
			fer_r  <= fer_nxt;
			tx_end_flag_r <= tx_end_flag_nxt;
			mpb_r  <= mpb_nxt;
			// reading a one arms its clear; both flags read together for the end request
			if (rd_stat) begin
				arm_r <= arm_r | stat_view;
			end else begin
				arm_r <= arm_r & ~stat_clr;
			end
		end
	end

	// interrupt capture, mask and outputs
	always @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			irq_stat_r     <= `UMTC_RST_IRQ;
			irq_mask_r     <= `UMTC_RST_IRQ;
			req_prev_r     <= `UMTC_RST_IRQ;
			O_RX_FULL_REQ  <= 1'b0;
			O_RX_ERROR_REQ <= 1'b0;
			O_TX_END_REQ   <= 1'b0;
			O_TX_EMPTY_REQ <= 1'b0;
			O_IRQ          <= 1'b0;
		end else if (I_CE) begin
			req_prev_r <= req_nxt;
			// rising request sets a sticky bit; a set beats a same-cycle one write
			irq_stat_r <= (req_nxt & ~req_prev_r) |
			              (irq_stat_r & ~({4{wr_istat}} & I_WDATA[3:0]));
			if (wr_imask) begin
				irq_mask_r <= I_WDATA[3:0];
			end
			O_RX_FULL_REQ  <= req_nxt[`UMTC_IRQ_RXF];
			O_RX_ERROR_REQ <= req_nxt[`UMTC_IRQ_RXE];
			O_TX_END_REQ   <= req_nxt[`UMTC_IRQ_TX_END_FLAG];
			O_TX_EMPTY_REQ <= req_nxt[`UMTC_IRQ_TXE];
			O_IRQ          <= |(irq_stat_r & irq_mask_r);
		end
	end

	// transmitter and enable outputs
	always @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_TX_DATA   <= `UMTC_RST_DATA;
			O_TX_VALID  <= 1'b0;
			O_RX_ENABLE <= 1'b0;
			O_TX_ENABLE <= 1'b0;
		end else if (I_CE) begin
			O_TX_DATA   <= tx_data_r;
			// valid drops the cycle after a take, so no byte is sent twice
			O_TX_VALID  <= ~tx_empty_flag_nxt & ctrl_nxt[`UMTC_CTRL_TE];
			O_RX_ENABLE <= ctrl_nxt[`UMTC_CTRL_RE];
			O_TX_ENABLE <= ctrl_nxt[`UMTC_CTRL_TE];
		end
	end

	// read port, data stands one cycle only
	always @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			O_RDATA <= 8'h00;
		end else if (I_CE) begin
			O_RDATA <= 8'h00;
			if (I_RD) begin
				case (I_ADDR)
					`UMTC_ADDR_MODE:     O_RDATA <= mode_r;
					`UMTC_ADDR_CTRL:     O_RDATA <= ctrl_r;
					`UMTC_ADDR_STATUS:   O_RDATA <= stat_view;
					`UMTC_ADDR_RXDATA:   O_RDATA <= rx_data_r;
					`UMTC_ADDR_TXDATA:   O_RDATA <= tx_data_r;
					`UMTC_ADDR_IRQ_STAT: O_RDATA <= {4'h0, irq_stat_r};
					`UMTC_ADDR_IRQ_MASK: O_RDATA <= {4'h0, irq_mask_r};
					// unmapped addresses read as zero
					default:             O_RDATA <= 8'h00;
				endcase
			end
		end
	end

endmodule

// [verification/umtc_ctrl_props.sv]
// Purpose: port checker for the serial control block
// Assumes: clock enable held high while checked
// Notes:   mirrors mode and control bits seen on the write port
`timescale 1ns/1ps
`include "umtc_consts.vh"
module umtc_ctrl_chk (
	input wire       I_SYS_CLK,
	input wire       I_RST,
	input wire [7:0] I_ADDR,
	input wire [7:0] I_WDATA,
	input wire       I_WR,
	input wire       I_RD,
	input wire       I_RX_FRAME_DONE,
	input wire       I_RX_MPB,
	input wire       I_RX_FERR,
	input wire       I_TX_MSB,
	input wire [7:0] O_RDATA,
	input wire       O_RX_FULL_REQ,
	input wire       O_RX_ERROR_REQ,
	input wire       O_TX_END_REQ
);
	reg  multiproc_irq_enable_r, rie_r, re_r, sync_r, mp_r;                // shadow bits
	wire ctrl_wr = I_WR && I_ADDR == `UMTC_ADDR_CTRL;      // control write
	wire tx_end_irq_enable_wr = ctrl_wr && I_WDATA[2];                  // enable raised
	wire filt    = multiproc_irq_enable_r && !sync_r && mp_r;              // filtering now
	wire rx_in   = I_RX_FRAME_DONE && re_r;                // frame taken
	// id frame clear wins over a same-cycle write
	always @(posedge I_SYS_CLK or posedge I_RST) begin
		if (I_RST) begin
			{multiproc_irq_enable_r, rie_r, re_r, sync_r, mp_r} <= 5'h00;
		end else begin
			if (ctrl_wr)
				{rie_r, re_r, multiproc_irq_enable_r} <= {I_WDATA[6], I_WDATA[4], I_WDATA[3]};
			if (I_WR && I_ADDR == `UMTC_ADDR_MODE)
				{sync_r, mp_r} <= {I_WDATA[7], I_WDATA[2]};
			if (rx_in && filt && I_RX_MPB)
				multiproc_irq_enable_r <= 1'h0;
		end
	end
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (I_RST);
	chk_rdata_idle: assert property (!I_RD |=> O_RDATA == 8'h00)
		else $error("read data not zero when idle");
	chk_tx_end_irq_enable_block: assert property (ctrl_wr && !I_WDATA[2] |=> ##1 !O_TX_END_REQ)
		else $error("tx end request passed while disabled");
	chk_tx_end_flag_cause: assert property ($rose(O_TX_END_REQ) |-> $past(I_TX_MSB, 2) || $past(tx_end_irq_enable_wr, 2))
		else $error("tx end request rose without cause");
	chk_filt_drop: assert property (rx_in && filt && !I_RX_MPB |=> ##1 !$rose(O_RX_FULL_REQ))
		else $error("filtered frame raised full request");
	chk_filt_noerr: assert property (rx_in && filt && !I_RX_MPB |=> ##1 !$rose(O_RX_ERROR_REQ))
		else $error("filtered frame raised error request");
	chk_id_req: assert property (rx_in && filt && I_RX_MPB && rie_r |=> ##1 O_RX_FULL_REQ)
		else $error("id frame gave no full request");
	chk_normal_rx: assert property (rx_in && !filt && !I_RX_FERR && rie_r |=> ##1 O_RX_FULL_REQ)
		else $error("normal frame gave no full request");
	chk_mp_ignored: assert property (rx_in && multiproc_irq_enable_r && (sync_r || !mp_r) && !I_RX_FERR && rie_r
		|=> ##1 O_RX_FULL_REQ)
		else $error("enable not ignored outside multiproc mode");
	chk_err_again: assert property (rx_in && !filt && I_RX_FERR && rie_r |=> ##1 O_RX_ERROR_REQ)
		else $error("framing error gave no error request");
	cover property (rx_in && filt && I_RX_MPB);
	cover property ($rose(O_TX_END_REQ));
	cover property (rx_in && multiproc_irq_enable_r && sync_r);
endmodule
bind umtc_ctrl umtc_ctrl_chk umtc_ctrl_chk_i (.I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .I_ADDR(I_ADDR),
	.I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .I_RX_FRAME_DONE(I_RX_FRAME_DONE), .I_RX_MPB(I_RX_MPB),
	.I_RX_FERR(I_RX_FERR), .I_TX_MSB(I_TX_MSB), .O_RDATA(O_RDATA), .O_RX_FULL_REQ(O_RX_FULL_REQ),
	.O_RX_ERROR_REQ(O_RX_ERROR_REQ), .O_TX_END_REQ(O_TX_END_REQ));

// [verification/umtc_station.sv]
// Purpose: remote station sending frames and draining the transmitter
// Assumes: one frame in flight at a time
// Notes:   frame lines are inverted outside the done pulse
`timescale 1ns/1ps
module umtc_station (
	input  wire       i_clk,
	input  wire       i_rst,
	input  wire       i_send,
	input  wire [7:0] i_byte,
	input  wire       i_mpb,
	input  wire       i_ferr,
	input  wire       i_tx_valid,
	output reg        o_done,
	output reg  [7:0] o_data,
	output reg        o_mpb,
	output reg        o_ferr,
	output reg        o_take,
	output reg        o_msb
);
	reg [3:0] rx_cnt_r;  // frame time left
	reg [3:0] tx_cnt_r;  // shift time left
	reg [9:0] frame_r;   // frame being received
	// slow frame delivery and slow transmit draining
	always @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			{o_done, o_take, o_msb, rx_cnt_r, tx_cnt_r} <= 11'h000;
			{o_ferr, o_mpb, o_data, frame_r} <= 20'h00000;
		end else begin
			o_done <= 1'h0;
			o_take <= 1'h0;
			o_msb <= 1'h0;
			if (o_done)
				{o_ferr, o_mpb, o_data} <= ~{o_ferr, o_mpb, o_data};
			if (i_send) begin
				frame_r <= {i_ferr, i_mpb, i_byte};
				rx_cnt_r <= 4'h6;
			end else if (rx_cnt_r != 4'h0) begin
				rx_cnt_r <= rx_cnt_r - 4'h1;
				if (rx_cnt_r == 4'h1) begin
					o_done <= 1'h1;
					{o_ferr, o_mpb, o_data} <= frame_r;
				end
			end
			if (tx_cnt_r != 4'h0)
				tx_cnt_r <= tx_cnt_r - 4'h1;
			else if (i_tx_valid)
				tx_cnt_r <= 4'h9;
			o_take <= tx_cnt_r == 4'h7;
			o_msb <= tx_cnt_r == 4'h1;
		end
	end
endmodule

// [verification/uart_multiproc_txend_ctrl_test.sv]
// Purpose: register level test of the serial control block
// Assumes: clock enable tied high
// Notes:   frames and transmit draining come from the station model
`timescale 1ns/1ps
`include "umtc_consts.vh"
module uart_multiproc_txend_ctrl_test;
	reg         clk, rst, wr_en, rd_en, send, smpb, sferr;
	reg  [7:0]  addr, wdata, sbyte;
	reg  [23:0] modes = 24'h040084;  // async mp, plain, sync mp
	reg  [23:0] ctrls = 24'h505858;
	wire        fdone, fmpb, fferr, take, msb, txv, rxf, rxe, tx_end_flag, irq, txe, rxen, txen;
	wire [7:0]  fdata, rdata, txd;
	integer     n_fail, tests_run, i, j;
	umtc_ctrl umtc_ctrl_i (.I_SYS_CLK(clk), .I_RST(rst), .I_CE(1'h1), .I_ADDR(addr), .I_WDATA(wdata),
		.I_WR(wr_en), .I_RD(rd_en), .I_RX_FRAME_DONE(fdone), .I_RX_DATA(fdata), .I_RX_MPB(fmpb),
		.I_RX_FERR(fferr), .I_TX_TAKE(take), .I_TX_MSB(msb), .O_RDATA(rdata), .O_TX_DATA(txd),
		.O_TX_VALID(txv), .O_RX_ENABLE(rxen), .O_TX_ENABLE(txen), .O_RX_FULL_REQ(rxf), .O_RX_ERROR_REQ(rxe),
		.O_TX_EMPTY_REQ(txe), .O_TX_END_REQ(tx_end_flag), .O_IRQ(irq));
	umtc_station umtc_station_i (.i_clk(clk), .i_rst(rst), .i_send(send), .i_byte(sbyte), .i_mpb(smpb),
		.i_ferr(sferr), .i_tx_valid(txv), .o_done(fdone), .o_data(fdata), .o_mpb(fmpb), .o_ferr(fferr),
		.o_take(take), .o_msb(msb));
	task print_verdict;
		begin
			$display("comparisons %0d mismatches %0d", tests_run, n_fail);
			if (n_fail == 0 && tests_run > 0)
				$display("All checks passed");
			else
				$display("Checks failed");
			$finish;
		end
	endtask
	task chk8(input [127:0] nm, input [7:0] e, input [7:0] g);
		begin
			tests_run = tests_run + 1;
			if (g !== e) begin
				n_fail = n_fail + 1;
				$display("ERROR %0s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	task chk1(input [127:0] nm, input e, input g);
		chk8(nm, {7'h00, e}, {7'h00, g});
	endtask
	task hang(input integer lim);
		if (i >= lim) begin
			n_fail = n_fail + 1;
			$display("ERROR wait expected %0d seen %0d", lim - 1, i);
			print_verdict;
		end
	endtask
	task wr(input [7:0] a, input [7:0] d);
		begin
			@(posedge clk);
			addr <= a;
			wdata <= d;
			wr_en <= 1'h1;
			@(posedge clk);
			wr_en <= 1'h0;
		end
	endtask
	task rd(input [7:0] a, input [7:0] e, input [127:0] nm);
		begin
			@(posedge clk);
			addr <= a;
			rd_en <= 1'h1;
			@(posedge clk);
			rd_en <= 1'h0;
			#1;
			chk8(nm, e, rdata);
		end
	endtask
	// send one frame, then wait until its requests have settled
	task frame(input [7:0] b, input m, input f);
		begin
			@(posedge clk);
			{send, sbyte, smpb, sferr} <= {1'h1, b, m, f};
			@(posedge clk);
			send <= 1'h0;
			for (i = 0; i < 20 && fdone !== 1'h1; i = i + 1) begin
				@(posedge clk);
				#1;
			end
			hang(20);
			repeat (2) @(posedge clk);
			#1;
		end
	endtask
	task settle;
		begin
			repeat (2) @(posedge clk);
			#1;
		end
	endtask
	initial begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end
	initial begin
		{rst, wr_en, rd_en, send, smpb, sferr, addr, wdata, sbyte} = {1'h1, 29'h00000000};
		n_fail = 0;
		tests_run = 0;
		repeat (3) @(posedge clk);
		rst <= 1'h0;
		rd(`UMTC_ADDR_CTRL, `UMTC_RST_CTRL, "ctrl reset");
		rd(`UMTC_ADDR_STATUS, `UMTC_RST_STATUS, "status reset");
		rd(8'h1C, 8'h00, "unmapped read");
		// tx end flag is set out of reset, so enabling passes it at once
		wr(`UMTC_ADDR_CTRL, 8'h04);
		settle;
		chk1("tx end req", 1'h1, tx_end_flag);
		rd(`UMTC_ADDR_IRQ_STAT, 8'h04, "irq status");
		chk1("irq masked", 1'h0, irq);
		wr(`UMTC_ADDR_IRQ_MASK, 8'h04);
		settle;
		chk1("irq raised", 1'h1, irq);
		wr(`UMTC_ADDR_IRQ_STAT, 8'h04);
		settle;
		chk1("irq cleared", 1'h0, irq);
		wr(`UMTC_ADDR_CTRL, 8'h00);
		settle;
		chk1("tx end req", 1'h0, tx_end_flag);
		wr(`UMTC_ADDR_TXDATA, 8'h5A);
		wr(`UMTC_ADDR_CTRL, 8'h24);
		rd(`UMTC_ADDR_STATUS, 8'h84, "status armed");
		wr(`UMTC_ADDR_STATUS, 8'h00);
		@(posedge clk);
		#1;
		chk1("tx end req", 1'h0, tx_end_flag);
		chk1("tx valid", 1'h1, txv);
		chk8("tx data", 8'h5A, txd);
		chk1("tx enable", 1'h1, txen);
		for (i = 0; i < 40 && tx_end_flag !== 1'h1; i = i + 1) begin
			@(posedge clk);
			#1;
		end
		hang(40);
		chk1("tx end req", 1'h1, tx_end_flag);
		rd(`UMTC_ADDR_STATUS, 8'h84, "status sent");
		// empty flag and transmit enable pass the empty request once its enable is set
		wr(`UMTC_ADDR_CTRL, 8'hA0);
		settle;
		chk1("tx empty req", 1'h1, txe);
		wr(`UMTC_ADDR_MODE, 8'h04);
		wr(`UMTC_ADDR_CTRL, 8'h58);
		frame(8'h11, 1'h0, 1'h0);
		chk1("rx full req", 1'h0, rxf);
		chk1("rx enable", 1'h1, rxen);
		frame(8'h22, 1'h0, 1'h1);
		chk1("rx err req", 1'h0, rxe);
		rd(`UMTC_ADDR_CTRL, 8'h58, "ctrl filtering");
		frame(8'hA5, 1'h1, 1'h0);
		chk1("rx full req", 1'h1, rxf);
		rd(`UMTC_ADDR_CTRL, 8'h50, "ctrl after id");
		rd(`UMTC_ADDR_STATUS, 8'hC6, "status after id");
		rd(`UMTC_ADDR_RXDATA, 8'hA5, "rx data");
		frame(8'h33, 1'h0, 1'h1);
		chk1("rx err req", 1'h1, rxe);
		// enable ignored in sync or plain mode, and no filter while clear
		for (j = 0; j < 3; j = j + 1) begin
			@(posedge clk);
			rst <= 1'h1;
			@(posedge clk);
			rst <= 1'h0;
			wr(`UMTC_ADDR_MODE, modes[8 * j +: 8]);
			wr(`UMTC_ADDR_CTRL, ctrls[8 * j +: 8]);
			frame(8'h3C, 1'h0, 1'h0);
			chk1("rx full req", 1'h1, rxf);
		end
		print_verdict;
	end
endmodule
